// ---- src/aex_map.vh ----
// constants for the asynchronous enclave exit unit
`ifndef AEX_MAP_VH
`define AEX_MAP_VH
// ----------------------------------------------------------------
// synthetic values
// ----------------------------------------------------------------
`define AEX_RESUME_LEAF     64'h0000_0000_0000_0003
`define AEX_FCW_FPERR       16'h037e
`define AEX_FCW_OTHER       16'h037f
`define AEX_FSW_FPERR       16'h8081
`define AEX_FSW_OTHER       16'h0000
`define AEX_VCS_SIMD        32'h0000_1f01
`define AEX_VCS_OTHER       32'h0000_1fb0
`define AEX_GP_ERRCODE      16'h0000
// flags bits cleared: cf pf af zf sf of rf
`define AEX_FLAGS_CLR_MASK  64'h0000_0000_0001_08d5
`define AEX_PAGE_SHIFT      12
`define AEX_CR2_LOW_MASK    64'hffff_ffff_ffff_f000
// ----------------------------------------------------------------
// event kinds on EVT_KIND_I
// ----------------------------------------------------------------
`define AEX_EVT_EXTINT      3'h0
`define AEX_EVT_NMI         3'h1
`define AEX_EVT_SMI         3'h2
`define AEX_EVT_EXCEPT      3'h3
`define AEX_EVT_VMEXIT      3'h4
// ----------------------------------------------------------------
// stack choice on STACK_SEL_O
// ----------------------------------------------------------------
`define AEX_STK_APP         2'h0
`define AEX_STK_RING        2'h1
`define AEX_STK_IST         2'h2
// ----------------------------------------------------------------
// slot register offsets
// ----------------------------------------------------------------
`define AEX_REG_CSLOT       4'h0
`define AEX_REG_NSLOT       4'h1
`define AEX_REG_OFFSET      4'h2
`define AEX_REG_FPAGES      4'h3
`define AEX_REG_BASE_LO     4'h4
`define AEX_REG_BASE_HI     4'h5
`define AEX_REG_CTRL        4'h6
`define AEX_REG_STATUS      4'h7
`endif

// ---- src/aex_frame_addr.v ----
// save-area frame address calculator
`default_nettype none
module aex_frame_addr #(
  parameter SLOT_W = 8
) (
  input  wire [63:0]       base_i,
  input  wire [63:0]       offset_i,
  input  wire [SLOT_W-1:0] slot_i,
  input  wire [SLOT_W-1:0] pages_i,
  output wire [63:0]       addr_o
);
  wire [2*SLOT_W-1:0] page_idx;
  assign page_idx = slot_i * pages_i;
  // each page is 4 kbyte
  assign addr_o = base_i + offset_i + {{(52-2*SLOT_W){1'b0}}, page_idx, 12'h000};
endmodule
`default_nettype wire

// ---- src/aex_exit_unit.v ----
// asynchronous enclave exit unit: save, synthetic state, slot stack
`default_nettype none
`include "aex_map.vh"
module aex_exit_unit #(
  parameter SLOT_W = 8
) (
  // clock and reset
  input  wire        CLOCK_I,
  input  wire        SYS_RST_I,
  // register port
  input  wire [3:0]  REG_ADDR_I,
  input  wire [31:0] REG_WDATA_I,
  input  wire        REG_WR_I,
  input  wire        REG_RD_I,
  output reg  [31:0] REG_RDATA_O,
  // core events
  input  wire        IN_ENCLAVE_I,
  input  wire        EVT_VALID_I,
  input  wire [2:0]  EVT_KIND_I,
  input  wire        EVT_FP_ERR_I,
  input  wire        EVT_SIMD_FP_I,
  input  wire        EVT_PF_I,
  input  wire        EVT_PF_VMEXIT_I,
  input  wire        EVT_PF_NESTED_I,
  input  wire        EVT_PRIV_CHG_I,
  input  wire        EVT_IST_I,
  input  wire        MODE64_I,
  input  wire        INVALIDATE_CACHE_NOFLUSH_EXEC_I,
  input  wire        ENTER_REQ_I,
  input  wire        RESUME_REQ_I,
  // thread context
  input  wire [63:0] TCS_PTR_I,
  input  wire [63:0] EXIT_PTR_I,
  input  wire [63:0] USER_SP_I,
  input  wire [63:0] USER_FP_I,
  input  wire [63:0] FLAGS_I,
  input  wire [63:0] FAULT_ADDR_I,
  input  wire [63:0] SEG_EXTRA0_I,
  input  wire [63:0] SEG_EXTRA1_I,
  // save memory handshake
  input  wire        SAVE_DONE_I,
  input  wire        RESTORE_DONE_I,
  output reg         SAVE_REQ_O,
  output reg         RESTORE_REQ_O,
  output reg  [63:0] FRAME_ADDR_O,
  output reg         EXTENDED_STATE_SAVE_LAYOUT64_O,
  // synthetic state
  output reg         SYNTH_LOAD_O,
  output reg         LEAVE_ENCLAVE_O,
  output reg         HANDLER_GO_O,
  output reg  [63:0] ACC_O,
  output reg  [63:0] BASE_O,
  output reg  [63:0] COUNT_O,
  output reg  [63:0] IP_O,
  output reg  [63:0] SP_O,
  output reg  [63:0] FP_O,
  output reg  [63:0] FLAGS_O,
  output reg         ZERO_DSI_O,
  output reg         ZERO_UPPER_O,
  output reg         FPU_INIT_O,
  output reg  [15:0] FCW_O,
  output reg  [15:0] FSW_O,
  output reg  [31:0] VCS_O,
  output reg  [63:0] FAULT_ADDR_O,
  output reg         FAULT_ADDR_WE_O,
  output reg  [63:0] SEG_EXTRA0_O,
  output reg  [63:0] SEG_EXTRA1_O,
  output reg  [1:0]  STACK_SEL_O,
  // entry answer and faults
  output reg         ENTER_OK_O,
  output reg         ENTER_FAIL_O,
  output reg         GP_FAULT_O,
  output reg  [15:0] GP_ERRCODE_O
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 3'h0;
  localparam ST_SAVE  = 3'h1;
  localparam ST_SYNTH = 3'h2;
  localparam ST_LEAVE = 3'h3;
  localparam ST_REST  = 3'h4;

  reg [2:0]        state_r;
  reg [SLOT_W-1:0] cslot_r;
  reg [SLOT_W-1:0] nslot_r;
  reg [SLOT_W-1:0] fpages_r;
  reg [63:0]       offset_r;
  reg [63:0]       base_r;
  reg              prot_on_r;
  reg              mode64_r;
  reg              fperr_r;
  reg              simd_r;
  reg              pf_clr_r;
  reg [63:0]       seg0_r;
  reg [63:0]       seg1_r;
  reg [2:0]        last_kind_r;
  reg [31:0]       rdata_nxt;
  wire [63:0]      frame_addr;
  wire             exit_evt;
  wire [SLOT_W-1:0] slot_sel;
  wire [63:0]      wmask;

  // a resume and the restore behind it use the last frame filled; an exit uses the next free one
  assign slot_sel = (state_r == ST_REST || (RESUME_REQ_I && !ENTER_REQ_I && !exit_evt)) ?
                    cslot_r - 1'b1 : cslot_r;
  assign exit_evt = EVT_VALID_I && IN_ENCLAVE_I && (EVT_KIND_I <= `AEX_EVT_VMEXIT);
  assign wmask    = mode64_r ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;

  aex_frame_addr #(
    .SLOT_W (SLOT_W)
  ) u_frame (
    .base_i   (base_r),
    .offset_i (offset_r),
    .slot_i   (slot_sel),
    .pages_i  (fpages_r),
    .addr_o   (frame_addr)
  );

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always @* begin
    case (REG_ADDR_I)
      `AEX_REG_CSLOT:   rdata_nxt = {{(32-SLOT_W){1'b0}}, cslot_r};
      `AEX_REG_NSLOT:   rdata_nxt = {{(32-SLOT_W){1'b0}}, nslot_r};
      `AEX_REG_OFFSET:  rdata_nxt = offset_r[31:0];
      `AEX_REG_FPAGES:  rdata_nxt = {{(32-SLOT_W){1'b0}}, fpages_r};
      `AEX_REG_BASE_LO: rdata_nxt = base_r[31:0];
      `AEX_REG_BASE_HI: rdata_nxt = base_r[63:32];
      `AEX_REG_CTRL:    rdata_nxt = {31'h0, prot_on_r};
      `AEX_REG_STATUS:  rdata_nxt = {26'h0, last_kind_r, state_r};
      default:          rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data stand for one cycle only; zero otherwise so stale data is never taken
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= rdata_nxt;
    end else begin
      REG_RDATA_O <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // configuration and slot stack
  // ----------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      nslot_r   <= {SLOT_W{1'b0}};
      // one page per frame after reset so frames never overlap before software sets a size
      fpages_r  <= {{(SLOT_W-1){1'b0}}, 1'b1};
      offset_r  <= 64'h0000_0000_0000_0000;
      base_r    <= 64'h0000_0000_0000_0000;
      prot_on_r <= 1'b0;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        `AEX_REG_NSLOT:   nslot_r   <= REG_WDATA_I[SLOT_W-1:0];
        `AEX_REG_OFFSET:  offset_r  <= {32'h0, REG_WDATA_I};
        `AEX_REG_FPAGES:  fpages_r  <= REG_WDATA_I[SLOT_W-1:0];
        `AEX_REG_BASE_LO: base_r[31:0]  <= REG_WDATA_I;
        `AEX_REG_BASE_HI: base_r[63:32] <= REG_WDATA_I;
        `AEX_REG_CTRL:    prot_on_r <= REG_WDATA_I[0];
        default:          prot_on_r <= prot_on_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // exit and resume sequencer
  // ----------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_r          <= ST_IDLE;
      cslot_r          <= {SLOT_W{1'b0}};
      mode64_r         <= 1'b0;
      fperr_r          <= 1'b0;
      simd_r           <= 1'b0;
      pf_clr_r         <= 1'b0;
      last_kind_r      <= 3'h0;
      seg0_r           <= 64'h0000_0000_0000_0000;
      seg1_r           <= 64'h0000_0000_0000_0000;
      SAVE_REQ_O       <= 1'b0;
      RESTORE_REQ_O    <= 1'b0;
      FRAME_ADDR_O     <= 64'h0000_0000_0000_0000;
      EXTENDED_STATE_SAVE_LAYOUT64_O <= 1'b0;
      SYNTH_LOAD_O     <= 1'b0;
      LEAVE_ENCLAVE_O  <= 1'b0;
      HANDLER_GO_O     <= 1'b0;
      ACC_O            <= 64'h0000_0000_0000_0000;
      BASE_O           <= 64'h0000_0000_0000_0000;
      COUNT_O          <= 64'h0000_0000_0000_0000;
      IP_O             <= 64'h0000_0000_0000_0000;
      SP_O             <= 64'h0000_0000_0000_0000;
      FP_O             <= 64'h0000_0000_0000_0000;
      FLAGS_O          <= 64'h0000_0000_0000_0000;
      ZERO_DSI_O       <= 1'b0;
      ZERO_UPPER_O     <= 1'b0;
      FPU_INIT_O       <= 1'b0;
      FCW_O            <= `AEX_FCW_OTHER;
      FSW_O            <= `AEX_FSW_OTHER;
      VCS_O            <= `AEX_VCS_OTHER;
      FAULT_ADDR_O     <= 64'h0000_0000_0000_0000;
      FAULT_ADDR_WE_O  <= 1'b0;
      SEG_EXTRA0_O     <= 64'h0000_0000_0000_0000;
      SEG_EXTRA1_O     <= 64'h0000_0000_0000_0000;
      STACK_SEL_O      <= `AEX_STK_APP;
      ENTER_OK_O       <= 1'b0;
      ENTER_FAIL_O     <= 1'b0;
      GP_FAULT_O       <= 1'b0;
      GP_ERRCODE_O     <= `AEX_GP_ERRCODE;
    end else begin
      // one-cycle strobes fall back by default
      SYNTH_LOAD_O    <= 1'b0;
      LEAVE_ENCLAVE_O <= 1'b0;
      HANDLER_GO_O    <= 1'b0;
      FAULT_ADDR_WE_O <= 1'b0;
      ENTER_OK_O      <= 1'b0;
      ENTER_FAIL_O    <= 1'b0;
      // every attempt faults while protections are on; nothing is counted or masked
      GP_FAULT_O      <= INVALIDATE_CACHE_NOFLUSH_EXEC_I && prot_on_r;
      GP_ERRCODE_O    <= `AEX_GP_ERRCODE;
      if (REG_WR_I && REG_ADDR_I == `AEX_REG_CSLOT && state_r == ST_IDLE) begin
        cslot_r <= REG_WDATA_I[SLOT_W-1:0];
      end
      case (state_r)
        ST_IDLE: begin
          if (exit_evt) begin
            // capture mode and fault causes; stack choice and context values other than the extra segments are still read from inputs at synthetic load
            mode64_r     <= MODE64_I;
            fperr_r      <= EVT_FP_ERR_I;
            simd_r       <= EVT_SIMD_FP_I;
            pf_clr_r     <= EVT_PF_I && !EVT_PF_VMEXIT_I && !EVT_PF_NESTED_I;
            last_kind_r  <= EVT_KIND_I;
            FRAME_ADDR_O <= frame_addr;
            EXTENDED_STATE_SAVE_LAYOUT64_O <= MODE64_I;
            SAVE_REQ_O   <= 1'b1;
            state_r      <= ST_SAVE;
          end else if (ENTER_REQ_I || RESUME_REQ_I) begin
            // latch extra segments at every entry or resume
            seg0_r <= SEG_EXTRA0_I;
            seg1_r <= SEG_EXTRA1_I;
            if (ENTER_REQ_I) begin
              ENTER_OK_O   <= (cslot_r < nslot_r);
              ENTER_FAIL_O <= !(cslot_r < nslot_r);
            end else if (cslot_r != {SLOT_W{1'b0}}) begin
              // the address must stand with the request: the memory side may start at once
              FRAME_ADDR_O  <= frame_addr;
              RESTORE_REQ_O <= 1'b1;
              state_r       <= ST_REST;
            end else begin
              ENTER_FAIL_O <= 1'b1;
            end
          end
        end
        ST_SAVE: begin
          // synthetic load waits for the save to land in the frame
          if (SAVE_DONE_I) begin
            SAVE_REQ_O <= 1'b0;
            cslot_r    <= cslot_r + 1'b1;
            state_r    <= ST_SYNTH;
          end
        end
        ST_SYNTH: begin
          SYNTH_LOAD_O <= 1'b1;
          ACC_O    <= `AEX_RESUME_LEAF;
          BASE_O   <= TCS_PTR_I & wmask;
          COUNT_O  <= EXIT_PTR_I & wmask;
          IP_O     <= EXIT_PTR_I & wmask;
          SP_O     <= USER_SP_I & wmask;
          FP_O     <= USER_FP_I & wmask;
          FLAGS_O  <= FLAGS_I & ~`AEX_FLAGS_CLR_MASK & wmask;
          ZERO_DSI_O   <= 1'b1;
          ZERO_UPPER_O <= mode64_r;
          FPU_INIT_O   <= 1'b1;
          FCW_O <= fperr_r ? `AEX_FCW_FPERR : `AEX_FCW_OTHER;
          FSW_O <= fperr_r ? `AEX_FSW_FPERR : `AEX_FSW_OTHER;
          VCS_O <= simd_r ? `AEX_VCS_SIMD : `AEX_VCS_OTHER;
          FAULT_ADDR_O    <= FAULT_ADDR_I & `AEX_CR2_LOW_MASK;
          FAULT_ADDR_WE_O <= pf_clr_r;
          SEG_EXTRA0_O <= seg0_r;
          SEG_EXTRA1_O <= seg1_r;
          if (EVT_IST_I) begin
            STACK_SEL_O <= `AEX_STK_IST;
          end else if (EVT_PRIV_CHG_I) begin
            STACK_SEL_O <= `AEX_STK_RING;
          end else begin
            STACK_SEL_O <= `AEX_STK_APP;
          end
          state_r <= ST_LEAVE;
        end
        ST_LEAVE: begin
          LEAVE_ENCLAVE_O <= 1'b1;
          HANDLER_GO_O    <= 1'b1;
          ZERO_DSI_O      <= 1'b0;
          ZERO_UPPER_O    <= 1'b0;
          FPU_INIT_O      <= 1'b0;
          state_r         <= ST_IDLE;
        end
        ST_REST: begin
          FRAME_ADDR_O <= frame_addr;
          if (RESTORE_DONE_I) begin
            RESTORE_REQ_O <= 1'b0;
            cslot_r       <= cslot_r - 1'b1;
            ENTER_OK_O    <= 1'b1;
            state_r       <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- verif/aex_exit_unit_checker.sv ----
// assertion checker for the asynchronous enclave exit unit
`default_nettype none
`include "aex_map.vh"
module aex_exit_unit_checker (
  // clock and reset
  input wire logic        CLOCK_I,
  input wire logic        SYS_RST_I,
  // inputs watched
  input wire logic        INVALIDATE_CACHE_NOFLUSH_EXEC_I,
  input wire logic        SAVE_DONE_I,
  input wire logic        ENTER_REQ_I,
  input wire logic        RESUME_REQ_I,
  input wire logic        RESTORE_DONE_I,
  // outputs watched
  input wire logic        SAVE_REQ_O,
  input wire logic        SYNTH_LOAD_O,
  input wire logic        LEAVE_ENCLAVE_O,
  input wire logic        HANDLER_GO_O,
  input wire logic [63:0] ACC_O,
  input wire logic        ZERO_DSI_O,
  input wire logic        FPU_INIT_O,
  input wire logic [15:0] FCW_O,
  input wire logic [15:0] FSW_O,
  input wire logic [31:0] VCS_O,
  input wire logic        ENTER_OK_O,
  input wire logic        ENTER_FAIL_O,
  input wire logic        GP_FAULT_O,
  input wire logic [15:0] GP_ERRCODE_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  // ----
  // exit sequence, entry answers and protection fault
  // ----
  sequence s_saved; SAVE_REQ_O && SAVE_DONE_I; endsequence
  sequence s_tail; !SAVE_REQ_O ##[1:2] SYNTH_LOAD_O ##1 (LEAVE_ENCLAVE_O && HANDLER_GO_O); endsequence
  a_save_then_load: assert property (s_saved |=> s_tail)
    else $error("synthetic load did not follow the save");
  a_req_held: assert property (SAVE_REQ_O && !SAVE_DONE_I |=> SAVE_REQ_O)
    else $error("save request dropped early");
  a_leave_after: assert property (LEAVE_ENCLAVE_O |-> $past(SYNTH_LOAD_O))
    else $error("enclave left without synthetic load");
  a_acc_resume: assert property (SYNTH_LOAD_O |-> !SAVE_REQ_O && ACC_O == 64'h3)
    else $error("accumulator not resume leaf");
  a_synth_zero: assert property (SYNTH_LOAD_O |-> ZERO_DSI_O && FPU_INIT_O)
    else $error("zeroing missing at synthetic load");
  a_fpu_pair: assert property ((FCW_O == `AEX_FCW_FPERR) == (FSW_O == `AEX_FSW_FPERR))
    else $error("fpu control and status disagree");
  a_vcs_legal: assert property (VCS_O == `AEX_VCS_SIMD || VCS_O == `AEX_VCS_OTHER)
    else $error("vector control value illegal");
  a_enter_excl: assert property ((ENTER_OK_O || ENTER_FAIL_O) |-> !(ENTER_OK_O && ENTER_FAIL_O) &&
    ($past(ENTER_REQ_I) || $past(RESUME_REQ_I) || $past(RESTORE_DONE_I)))
    else $error("entry answer without request or both ok and failed");
  a_gp_cause: assert property (GP_FAULT_O |-> $past(INVALIDATE_CACHE_NOFLUSH_EXEC_I) && GP_ERRCODE_O == 16'h0)
    else $error("protection fault without cause");
endmodule
bind aex_exit_unit aex_exit_unit_checker chk_u (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
  .INVALIDATE_CACHE_NOFLUSH_EXEC_I(INVALIDATE_CACHE_NOFLUSH_EXEC_I), .SAVE_DONE_I(SAVE_DONE_I), .SAVE_REQ_O(SAVE_REQ_O),
  .ENTER_REQ_I(ENTER_REQ_I), .RESUME_REQ_I(RESUME_REQ_I), .RESTORE_DONE_I(RESTORE_DONE_I),
  .SYNTH_LOAD_O(SYNTH_LOAD_O), .LEAVE_ENCLAVE_O(LEAVE_ENCLAVE_O), .HANDLER_GO_O(HANDLER_GO_O),
  .ACC_O(ACC_O), .ZERO_DSI_O(ZERO_DSI_O), .FPU_INIT_O(FPU_INIT_O), .FCW_O(FCW_O),
  .FSW_O(FSW_O), .VCS_O(VCS_O), .ENTER_OK_O(ENTER_OK_O), .ENTER_FAIL_O(ENTER_FAIL_O),
  .GP_FAULT_O(GP_FAULT_O), .GP_ERRCODE_O(GP_ERRCODE_O));
`default_nettype wire

// ---- verif/aex_exit_unit_test.sv ----
// self-checking bench for the asynchronous enclave exit unit
`default_nettype none
`include "aex_map.vh"
module aex_exit_unit_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLOCK_I, SYS_RST_I, REG_WR_I, REG_RD_I, IN_ENCLAVE_I, EVT_VALID_I, EVT_FP_ERR_I;
  logic        EVT_SIMD_FP_I, EVT_PF_I, EVT_PF_VMEXIT_I, EVT_PF_NESTED_I, EVT_PRIV_CHG_I;
  logic        EVT_IST_I, MODE64_I, INVALIDATE_CACHE_NOFLUSH_EXEC_I, ENTER_REQ_I, RESUME_REQ_I, SAVE_DONE_I;
  logic        RESTORE_DONE_I, SAVE_REQ_O, RESTORE_REQ_O, EXTENDED_STATE_SAVE_LAYOUT64_O, SYNTH_LOAD_O;
  logic        LEAVE_ENCLAVE_O, HANDLER_GO_O, ZERO_DSI_O, ZERO_UPPER_O, FPU_INIT_O;
  logic        FAULT_ADDR_WE_O, ENTER_OK_O, ENTER_FAIL_O, GP_FAULT_O;
  logic [1:0]  STACK_SEL_O;
  logic [2:0]  EVT_KIND_I;
  logic [3:0]  REG_ADDR_I;
  logic [15:0] FCW_O, FSW_O, GP_ERRCODE_O;
  logic [31:0] REG_WDATA_I, REG_RDATA_O, VCS_O;
  logic [63:0] TCS_PTR_I, EXIT_PTR_I, USER_SP_I, USER_FP_I, FLAGS_I, FAULT_ADDR_I;
  logic [63:0] SEG_EXTRA0_I, SEG_EXTRA1_I, FRAME_ADDR_O, ACC_O, BASE_O, COUNT_O, IP_O;
  logic [63:0] SP_O, FP_O, FLAGS_O, FAULT_ADDR_O, SEG_EXTRA0_O, SEG_EXTRA1_O, seg0, seg1;
  logic [3:0]  flags_w;
  int          n_fail, n_checks, slot;
  // ----
  // exit table: {fp, simd, pf, pf_vm, pf_nested, mode64, priv, ist}
  // ----
  logic [2:0]  kinds [7] = '{`AEX_EVT_EXTINT, `AEX_EVT_NMI, `AEX_EVT_SMI, `AEX_EVT_EXCEPT,
                             `AEX_EVT_EXCEPT, `AEX_EVT_VMEXIT, `AEX_EVT_EXCEPT};
  logic [7:0]  fl [7] = '{8'h04, 8'h02, 8'h07, 8'h82, 8'h64, 8'h34, 8'h28};
  assign flags_w = {ENTER_OK_O | ENTER_FAIL_O, RESTORE_REQ_O, SYNTH_LOAD_O, SAVE_REQ_O};
  aex_exit_unit dut_u (.*);
  always #2.5 CLOCK_I = ~CLOCK_I;
  // ----
  // tasks
  // ----
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait on one handshake flag, looked at just after each edge
  task automatic wt(input int w);
    for (int n = 0; n < 20; n++) begin
      #1;
      if (flags_w[w] === 1'b1) return;
      @(posedge CLOCK_I);
    end
    n_fail++;
    $display("BAD %0t wait ran out", $time);
    wrap_up();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLOCK_I);
    REG_WR_I <= 1'b1;
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    @(posedge CLOCK_I);
    REG_WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge CLOCK_I);
    REG_RD_I <= 1'b1;
    REG_ADDR_I <= a;
    @(posedge CLOCK_I);
    REG_RD_I <= 1'b0;
    #1 chk(REG_RDATA_O, e);
  endtask
  function automatic logic [63:0] fr(input int s);
    return 64'h0000_0001_0010_2000 + 64'(s * 8192);
  endfunction
  task automatic enter(input logic ok);
    @(posedge CLOCK_I);
    ENTER_REQ_I <= 1'b1;
    @(posedge CLOCK_I);
    ENTER_REQ_I <= 1'b0;
    wt(3);
    chk({ENTER_OK_O, ENTER_FAIL_O}, {ok, ~ok});
  endtask
  task automatic aexit(input logic [2:0] k, input logic [7:0] f);
    logic [63:0] m;
    m = f[2] ? '1 : 64'h0000_0000_ffff_ffff;
    @(posedge CLOCK_I);
    EVT_VALID_I <= 1'b1;
    EVT_KIND_I <= k;
    {EVT_FP_ERR_I, EVT_SIMD_FP_I, EVT_PF_I, EVT_PF_VMEXIT_I, EVT_PF_NESTED_I, MODE64_I,
      EVT_PRIV_CHG_I, EVT_IST_I} <= f;
    @(posedge CLOCK_I);
    EVT_VALID_I <= 1'b0;
    wt(0);
    chk(FRAME_ADDR_O, fr(slot));
    chk(EXTENDED_STATE_SAVE_LAYOUT64_O, f[2]);
    @(posedge CLOCK_I);
    SAVE_DONE_I <= 1'b1;
    @(posedge CLOCK_I);
    SAVE_DONE_I <= 1'b0;
    wt(1);
    slot++;
    chk(ACC_O, `AEX_RESUME_LEAF & m);
    chk(BASE_O, TCS_PTR_I & m);
    chk(COUNT_O, EXIT_PTR_I & m);
    chk(IP_O, EXIT_PTR_I & m);
    chk(SP_O, USER_SP_I & m);
    chk(FP_O, USER_FP_I & m);
    chk(FLAGS_O, FLAGS_I & ~`AEX_FLAGS_CLR_MASK & m);
    chk({ZERO_DSI_O, ZERO_UPPER_O, FPU_INIT_O}, {1'b1, f[2], 1'b1});
    chk(FCW_O, f[7] ? `AEX_FCW_FPERR : `AEX_FCW_OTHER);
    chk(FSW_O, f[7] ? `AEX_FSW_FPERR : `AEX_FSW_OTHER);
    chk(VCS_O, f[6] ? `AEX_VCS_SIMD : `AEX_VCS_OTHER);
    chk(STACK_SEL_O, f[0] ? `AEX_STK_IST : f[1] ? `AEX_STK_RING : `AEX_STK_APP);
    chk(FAULT_ADDR_WE_O, f[5] & ~f[4] & ~f[3]);
    if (f[5] & ~f[4] & ~f[3]) chk(FAULT_ADDR_O, FAULT_ADDR_I & `AEX_CR2_LOW_MASK);
    chk(SEG_EXTRA0_O, seg0);
    chk(SEG_EXTRA1_O, seg1);
    @(posedge CLOCK_I);
    #1 chk({LEAVE_ENCLAVE_O, HANDLER_GO_O}, 2'b11);
  endtask
  task automatic invalidate_cache_noflush(input logic on);
    @(posedge CLOCK_I);
    INVALIDATE_CACHE_NOFLUSH_EXEC_I <= 1'b1;
    @(posedge CLOCK_I);
    INVALIDATE_CACHE_NOFLUSH_EXEC_I <= 1'b0;
    #1 chk({GP_FAULT_O, GP_ERRCODE_O}, {on, 16'h0});
  endtask
  // resume restoring frame s, or expecting refusal when s is negative
  task automatic resume(input int s);
    @(posedge CLOCK_I);
    RESUME_REQ_I <= 1'b1;
    @(posedge CLOCK_I);
    RESUME_REQ_I <= 1'b0;
    if (s < 0) begin
      wt(3);
      chk({ENTER_OK_O, ENTER_FAIL_O, RESTORE_REQ_O}, 3'h2);
    end else begin
      wt(2);
      chk(FRAME_ADDR_O, fr(s));
      @(posedge CLOCK_I);
      RESTORE_DONE_I <= 1'b1;
      @(posedge CLOCK_I);
      RESTORE_DONE_I <= 1'b0;
      wt(3);
      chk({ENTER_OK_O, ENTER_FAIL_O, RESTORE_REQ_O}, 3'h4);
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {CLOCK_I, REG_WR_I, REG_RD_I, IN_ENCLAVE_I, EVT_VALID_I, INVALIDATE_CACHE_NOFLUSH_EXEC_I, ENTER_REQ_I} = '0;
    {RESUME_REQ_I, SAVE_DONE_I, RESTORE_DONE_I, REG_ADDR_I, REG_WDATA_I, EVT_KIND_I} = '0;
    {EVT_FP_ERR_I, EVT_SIMD_FP_I, EVT_PF_I, EVT_PF_VMEXIT_I, EVT_PF_NESTED_I} = '0;
    {EVT_PRIV_CHG_I, EVT_IST_I, MODE64_I, n_fail, n_checks, slot} = '0;
    SYS_RST_I = 1'b1;
    TCS_PTR_I = 64'h0000_7f00_1234_5000;
    EXIT_PTR_I = 64'h0000_7f00_0040_1230;
    USER_SP_I = 64'h0000_7ffe_dead_bee0;
    USER_FP_I = 64'h0000_7ffe_dead_bf00;
    FLAGS_I = 64'h0000_0000_0003_0fff;
    FAULT_ADDR_I = 64'h0000_1234_5678_9abc;
    seg0 = 64'h0000_0000_0000_aa00;
    seg1 = 64'h0000_0000_0000_bb00;
    {SEG_EXTRA0_I, SEG_EXTRA1_I} = {seg0, seg1};
    repeat (4) @(posedge CLOCK_I);
    SYS_RST_I <= 1'b0;
    #1 chk({FCW_O, FSW_O, VCS_O}, {`AEX_FCW_OTHER, `AEX_FSW_OTHER, `AEX_VCS_OTHER});
    rd(`AEX_REG_FPAGES, 32'h1);
    rd(4'hf, 32'h0);
    wr(`AEX_REG_NSLOT, 32'h8);
    wr(`AEX_REG_FPAGES, 32'h2);
    wr(`AEX_REG_OFFSET, 32'h2000);
    wr(`AEX_REG_BASE_LO, 32'h0010_0000);
    wr(`AEX_REG_BASE_HI, 32'h1);
    IN_ENCLAVE_I <= 1'b1;
    enter(1'b1);
    // later changes must not reach the synthetic segments loaded at exit
    {SEG_EXTRA0_I, SEG_EXTRA1_I} <= '1;
    for (int i = 0; i < 7; i++) aexit(kinds[i], fl[i]);
    rd(`AEX_REG_CSLOT, 32'h7);
    rd(`AEX_REG_STATUS, 32'h18);
    enter(1'b1);
    wr(`AEX_REG_NSLOT, 32'h7);
    enter(1'b0);
    resume(6);
    rd(`AEX_REG_CSLOT, 32'h6);
    resume(5);
    rd(`AEX_REG_CSLOT, 32'h5);
    wr(`AEX_REG_CSLOT, 32'h0);
    resume(-1);
    // an unknown kind inside, then a known kind outside, must not start a save
    for (int i = 0; i < 2; i++) begin
      @(posedge CLOCK_I);
      EVT_VALID_I <= 1'b1;
      EVT_KIND_I <= (i == 0) ? 3'h5 : `AEX_EVT_EXTINT;
      IN_ENCLAVE_I <= (i == 0);
      @(posedge CLOCK_I);
      EVT_VALID_I <= 1'b0;
      repeat (3) begin
        #1 chk(SAVE_REQ_O, 1'b0);
        @(posedge CLOCK_I);
      end
    end
    invalidate_cache_noflush(1'b0);
    wr(`AEX_REG_CTRL, 32'h1);
    rd(`AEX_REG_CTRL, 32'h1);
    invalidate_cache_noflush(1'b1);
    invalidate_cache_noflush(1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
